// >>> hw/jtc_tap.sv
// Overview of operation
// - sixteen states, tms sampled each tck rise
// - reset state disables test, loads idcode
// - five tms highs reach reset, stay there
// - power up enters reset without tck
// - idle holds on low, high to select-dr
// - select-dr: low capture-dr, high select-ir
// - capture-dr samples pins for extest/sample
// - capture-dr: high exit1-dr, low shift-dr
// - shift-dr shifts toward tdo, high exits
// - exit1-dr: high update-dr, low pause-dr
// - pause-dr holds on low, high exit2-dr
// - exit2-dr: high update-dr, low shift-dr
// - boundary output latches on update-dr fall
// - select-ir: low capture-ir, high reset
// - capture-ir loads fixed pattern 100
// - capture-ir: high exit1-ir, low shift-ir
// - shift-ir shifts toward tdo, high exits
// - instruction scan keeps instruction, data
// - exit1-ir: high update-ir, low pause-ir
// - pause-ir holds on low, high exit2-ir
// - exit2-ir: high update-ir, low shift-ir
// - update-ir latches instruction on tck fall
`timescale 1ns/1ps
`include "jtc_defines.svh"
module jtc_tap
   import jtc_pkg::*;
#(
   parameter int                  BSR_LEN = `JTC_BSR_LEN,
   // value is arbitrary, lsb set as identity codes require
   parameter logic [`JTC_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   input  wire logic               tck_in,
   input  wire logic               tms_in,
   input  wire logic               tdi_in,
   input  wire logic [BSR_LEN-1:0] pin_in,
   output logic                    tdo_out,
   output logic                    tdo_oe_out,
   output logic [BSR_LEN-1:0]      pin_out,
   output logic                    test_mode_out
);
   // ***************************************
   // declarations
   // ***************************************
   localparam jtc_tap_regs_t RESET_VAL = '{
      state     : JTC_TLR,
      tck_d     : 1'b0,
      ir_sh     : '0,
      ir        : `JTC_OP_IDCODE,
      byp       : 1'b0,
      id_sh     : '0,
      tdo       : 1'b1,
      tdo_oe    : 1'b0,
      test_mode : 1'b0
   };
   jtc_tap_regs_t r_reg;                   // registered state
   jtc_tap_regs_t r;                       // read view of the register
   jtc_tap_regs_t r_next;                  // next state
   jtc_pins_t     pins_raw;                // pins as they arrive
   jtc_pins_t     pins_s;                  // pins after two flops
   logic          rise;                    // tck rising edge seen
   logic          fall;                    // tck falling edge seen
   logic          tms_s;                   // synced mode select
   logic          bsr_sel;                 // boundary chain selected
   logic          bsr_cap;                 // chain capture strobe
   logic          bsr_shift;               // chain shift strobe
   logic          bsr_upd;                 // chain update strobe
   logic          bsr_ser;                 // chain serial out
   logic [BSR_LEN-1:0] bsr_chain;          // chain shift stages
   logic          dr_ser;                  // selected data serial out
   logic          shifting;                // in either shift state

   // ***************************************
   // pin synchroniser
   // ***************************************
   // tck is only sampled, so its edges lag by a few clocks
   assign pins_raw = '{tck: tck_in, tms: tms_in, tdi: tdi_in};
   jtc_sync u_sync (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .pins_in  (pins_raw),
      .pins_out (pins_s)
   );
   assign tms_s = pins_s.tms;
   // edges from the second stage against its delayed copy
   assign rise  = pins_s.tck & ~r.tck_d;
   assign fall  = ~pins_s.tck & r.tck_d;

   // ***************************************
   // data register selection
   // ***************************************
   // extest and sample put the boundary chain in the path
   assign bsr_sel   = (r.ir == `JTC_OP_EXTEST) || (r.ir == `JTC_OP_SAMPLE);
   assign bsr_cap   = bsr_sel && rise && (r.state == JTC_CAP_DR);
   assign bsr_shift = bsr_sel && rise && (r.state == JTC_SHIFT_DR);
   assign bsr_upd   = bsr_sel && fall && (r.state == JTC_UPD_DR);
   assign shifting  = (r.state == JTC_SHIFT_DR) || (r.state == JTC_SHIFT_IR);
   // pick the serial bit of the selected data register
   always_comb begin
      case (r.ir)
         `JTC_OP_EXTEST,
         `JTC_OP_SAMPLE: dr_ser = bsr_ser;
         `JTC_OP_IDCODE: dr_ser = r.id_sh[0];
         default:        dr_ser = r.byp;  // unknown codes act as bypass
      endcase
   end

   // ***************************************
   // boundary scan chain
   // ***************************************
   jtc_bsr #(
      .LEN (BSR_LEN)
   ) u_bsr (
      .clk_in     (clk_in),
      .reset_in   (reset_in),
      .capture_in (bsr_cap),
      .shift_in   (bsr_shift),
      .update_in  (bsr_upd),
      .tdi_in     (pins_s.tdi),
      .pin_in     (pin_in),
      .serial_out (bsr_ser),
      .chain_out  (bsr_chain),
      .par_out    (pin_out)
   );

   // ***************************************
   // next state logic
   // ***************************************
   always_comb begin
      r_next       = r;
      r_next.tck_d = pins_s.tck;
      // the machine only moves on a tck rise
      if (rise) begin
         case (r.state)
            JTC_TLR:      r_next.state = tms_s ? JTC_TLR : JTC_IDLE;
            JTC_IDLE:     r_next.state = tms_s ? JTC_SEL_DR : JTC_IDLE;
            JTC_SEL_DR:   r_next.state = tms_s ? JTC_SEL_IR : JTC_CAP_DR;
            JTC_CAP_DR:   r_next.state = tms_s ? JTC_EXIT1_DR : JTC_SHIFT_DR;
            JTC_SHIFT_DR: r_next.state = tms_s ? JTC_EXIT1_DR : JTC_SHIFT_DR;
            JTC_EXIT1_DR: r_next.state = tms_s ? JTC_UPD_DR : JTC_PAUSE_DR;
            JTC_PAUSE_DR: r_next.state = tms_s ? JTC_EXIT2_DR : JTC_PAUSE_DR;
            JTC_EXIT2_DR: r_next.state = tms_s ? JTC_UPD_DR : JTC_SHIFT_DR;
            JTC_UPD_DR:   r_next.state = tms_s ? JTC_SEL_DR : JTC_IDLE;
            JTC_SEL_IR:   r_next.state = tms_s ? JTC_TLR : JTC_CAP_IR;
            JTC_CAP_IR:   r_next.state = tms_s ? JTC_EXIT1_IR : JTC_SHIFT_IR;
            JTC_SHIFT_IR: r_next.state = tms_s ? JTC_EXIT1_IR : JTC_SHIFT_IR;
            JTC_EXIT1_IR: r_next.state = tms_s ? JTC_UPD_IR : JTC_PAUSE_IR;
            JTC_PAUSE_IR: r_next.state = tms_s ? JTC_EXIT2_IR : JTC_PAUSE_IR;
            JTC_EXIT2_IR: r_next.state = tms_s ? JTC_UPD_IR : JTC_SHIFT_IR;
            JTC_UPD_IR:   r_next.state = tms_s ? JTC_SEL_DR : JTC_IDLE;
            default:      r_next.state = JTC_TLR;
         endcase
         // instruction shifter works only in its own states
         if (r.state == JTC_CAP_IR) begin
            r_next.ir_sh = `JTC_IR_CAPTURE;
         end else if (r.state == JTC_SHIFT_IR) begin
            r_next.ir_sh = {pins_s.tdi, r.ir_sh[`JTC_IR_W-1:1]};
         end
         // bypass and id shifters; pause and exit states hold
         if (r.state == JTC_CAP_DR) begin
            r_next.byp   = 1'b0;
            if (r.ir == `JTC_OP_IDCODE) r_next.id_sh = ID_CODE;
         end else if (r.state == JTC_SHIFT_DR) begin
            r_next.byp   = pins_s.tdi;
            if (r.ir == `JTC_OP_IDCODE) begin
               r_next.id_sh = {pins_s.tdi, r.id_sh[`JTC_ID_W-1:1]};
            end
         end
      end
      // tdo and its enable change on the fall so the tester samples a steady tdo
      if (fall) begin
         r_next.tdo_oe = shifting;
         if (r.state == JTC_SHIFT_IR) r_next.tdo = r.ir_sh[0];
         else if (r.state == JTC_SHIFT_DR) r_next.tdo = dr_ser;
         else r_next.tdo = 1'b1;
         // a shifted instruction takes effect only here
         if (r.state == JTC_UPD_IR) r_next.ir = r.ir_sh;
      end
      // reset state forces the id code and normal pin operation
      if (r.state == JTC_TLR) r_next.ir = `JTC_OP_IDCODE;
      r_next.test_mode = (r.ir == `JTC_OP_EXTEST) && (r.state != JTC_TLR);
   end

   // ***************************************
   // state register
   // ***************************************
   // async reset stands for power up: no tck needed
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) r_reg <= RESET_VAL;
      else          r_reg <= r_next;
   end
   // every read goes through this plain view of the register
   assign r = r_reg;

   // ***************************************
   // outputs
   // ***************************************
   assign tdo_out       = r.tdo;
   assign tdo_oe_out    = r.tdo_oe;
   assign test_mode_out = r.test_mode;

   // ***************************************
   // assertion helpers
   // ***************************************
   logic [2:0] tms_cnt_reg; // consecutive rises with tms high, saturating
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) tms_cnt_reg <= 3'h0;
      else if (rise) begin
         if (!tms_s) tms_cnt_reg <= 3'h0;
         else if (tms_cnt_reg != `JTC_TLR_TMS) tms_cnt_reg <= tms_cnt_reg + 3'h1;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   sequence s_rise_in(jtc_state_t st, logic lvl);
      (r.state == st) && rise && (tms_s == lvl);
   endsequence
   sequence s_fall_in(jtc_state_t st);
      (r.state == st) && fall;
   endsequence

   a_five_tms_reset: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (tms_cnt_reg == `JTC_TLR_TMS) |-> (r.state == JTC_TLR))
      else $error("five tms highs did not reach reset");
   a_idle_stays: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_IDLE, 1'b0) |=> (r.state == JTC_IDLE))
      else $error("idle left with tms low");
   a_sel_dr_branch: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_SEL_DR, 1'b1) |=> (r.state == JTC_SEL_IR))
      else $error("select-dr high did not reach select-ir");
   a_sel_ir_reset: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_SEL_IR, 1'b1) |=> (r.state == JTC_TLR))
      else $error("select-ir high did not reach reset");
   a_dr_walk_update: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_EXIT1_DR, 1'b1) |=> (r.state == JTC_UPD_DR))
      else $error("exit1-dr high did not reach update-dr");
   a_capture_ir_fixed: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_rise_in(JTC_CAP_IR, 1'b0) or s_rise_in(JTC_CAP_IR, 1'b1))
      |=> (r.ir_sh == `JTC_IR_CAPTURE))
      else $error("capture-ir did not load pattern");
   a_ir_latch_fall: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_fall_in(JTC_UPD_IR) |=> (r.ir == $past(r.ir_sh)))
      else $error("update-ir did not latch instruction");
   a_ir_held: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (r.state != JTC_TLR) && !(r.state == JTC_UPD_IR && fall) |=> $stable(r.ir))
      else $error("instruction changed outside update");
   a_tlr_idcode: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (r.state == JTC_TLR) |=> (r.ir == `JTC_OP_IDCODE) && !r.test_mode)
      else $error("reset state left test logic on");
   a_bsr_par_held: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !bsr_upd |=> $stable(pin_out))
      else $error("boundary output changed outside update");
   a_bsr_capture: assert property (
      @(posedge clk_in) disable iff (reset_in)
      bsr_cap |=> (bsr_chain == $past(pin_in)))
      else $error("capture-dr did not sample pins");
   a_tdo_enable: assert property (
      @(posedge clk_in) disable iff (reset_in)
      fall |=> (tdo_oe_out == $past(shifting)))
      else $error("tdo enable wrong for state");

   // ***************************************
   // branch checks on a subset of the state steps
   // ***************************************
   a_tlr_to_idle: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_TLR, 1'b0) |=> (r.state == JTC_IDLE))
      else $error("reset state low did not reach idle");
   a_idle_to_sel: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_IDLE, 1'b1) |=> (r.state == JTC_SEL_DR))
      else $error("idle high did not reach select-dr");
   a_sel_dr_capture: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_SEL_DR, 1'b0) |=> (r.state == JTC_CAP_DR))
      else $error("select-dr low did not reach capture-dr");
   a_cap_dr_shift: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_CAP_DR, 1'b0) |=> (r.state == JTC_SHIFT_DR))
      else $error("capture-dr low did not reach shift-dr");
   a_shift_dr_exit: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_SHIFT_DR, 1'b1) |=> (r.state == JTC_EXIT1_DR))
      else $error("shift-dr high did not reach exit1-dr");
   a_pause_dr_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_PAUSE_DR, 1'b0) |=> (r.state == JTC_PAUSE_DR))
      else $error("pause-dr left with tms low");
   a_exit2_dr_update: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_EXIT2_DR, 1'b1) |=> (r.state == JTC_UPD_DR))
      else $error("exit2-dr high did not reach update-dr");
   a_cap_ir_shift: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_CAP_IR, 1'b0) |=> (r.state == JTC_SHIFT_IR))
      else $error("capture-ir low did not reach shift-ir");
   a_shift_ir_step: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_SHIFT_IR, 1'b0) |=> (r.ir_sh[`JTC_IR_W-2:0] == $past(r.ir_sh[`JTC_IR_W-1:1])))
      else $error("shift-ir did not move toward tdo");
   a_exit1_ir_pause: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_EXIT1_IR, 1'b0) |=> (r.state == JTC_PAUSE_IR))
      else $error("exit1-ir low did not reach pause-ir");
   a_pause_ir_exit: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_PAUSE_IR, 1'b1) |=> (r.state == JTC_EXIT2_IR))
      else $error("pause-ir high did not reach exit2-ir");
   a_exit2_ir_shift: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_EXIT2_IR, 1'b0) |=> (r.state == JTC_SHIFT_IR))
      else $error("exit2-ir low did not reach shift-ir");
   a_upd_to_idle: assert property (
      @(posedge clk_in) disable iff (reset_in)
      (s_rise_in(JTC_UPD_DR, 1'b0) or s_rise_in(JTC_UPD_IR, 1'b0))
      |=> (r.state == JTC_IDLE))
      else $error("update low did not reach idle");
   a_state_still: assert property (
      @(posedge clk_in) disable iff (reset_in)
      !rise |=> $stable(r.state))
      else $error("state moved without a tck rise");
   a_pause_ir_hold: assert property (
      @(posedge clk_in) disable iff (reset_in)
      s_rise_in(JTC_PAUSE_IR, 1'b0) |=> (r.state == JTC_PAUSE_IR) && $stable(r.ir_sh))
      else $error("pause-ir did not hold");
endmodule // jtc_tap

// >>> hw/jtc_defines.svh
`ifndef JTC_DEFINES_SVH
`define JTC_DEFINES_SVH
// ***************************************
// instruction register
// ***************************************
`define JTC_IR_W       3
`define JTC_IR_CAPTURE 3'h4
`define JTC_OP_EXTEST  3'h0
`define JTC_OP_SAMPLE  3'h1
`define JTC_OP_IDCODE  3'h2
`define JTC_OP_BYPASS  3'h7
// ***************************************
// data registers and counts
// ***************************************
`define JTC_ID_W       32
`define JTC_BSR_LEN    16
`define JTC_PIN_W      3
`define JTC_TLR_TMS    3'h5
`endif

// >>> hw/jtc_pkg.sv
`include "jtc_defines.svh"
package jtc_pkg;
   // ***************************************
   // controller states
   // ***************************************
   typedef enum logic [3:0] {
      JTC_TLR, JTC_IDLE, JTC_SEL_DR, JTC_CAP_DR,
      JTC_SHIFT_DR, JTC_EXIT1_DR, JTC_PAUSE_DR, JTC_EXIT2_DR,
      JTC_UPD_DR, JTC_SEL_IR, JTC_CAP_IR, JTC_SHIFT_IR,
      JTC_EXIT1_IR, JTC_PAUSE_IR, JTC_EXIT2_IR, JTC_UPD_IR
   } jtc_state_t;
   // ***************************************
   // test port pins, sampled together
   // ***************************************
   typedef struct packed {
      logic tck;                            // test clock level
      logic tms;                            // mode select level
      logic tdi;                            // serial data in
   } jtc_pins_t;
   // ***************************************
   // whole state of the controller
   // ***************************************
   typedef struct packed {
      jtc_state_t                state;     // current tap state
      logic                      tck_d;     // last tck level
      logic [`JTC_IR_W-1:0]      ir_sh;     // instruction shifter
      logic [`JTC_IR_W-1:0]      ir;        // current instruction
      logic                      byp;       // bypass stage
      logic [`JTC_ID_W-1:0]      id_sh;     // id code shifter
      logic                      tdo;       // serial out level
      logic                      tdo_oe;    // serial out enable
      logic                      test_mode; // pins under test
   } jtc_tap_regs_t;
endpackage

// >>> hw/jtc_sync.sv
`timescale 1ns/1ps
module jtc_sync
   import jtc_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      reset_in,
   input  wire jtc_pins_t pins_in,
   output jtc_pins_t      pins_out
);
   // ***************************************
   // two flop synchroniser
   // ***************************************
   typedef struct packed {
      jtc_pins_t s1;                        // first stage, only s2 reads it
      jtc_pins_t s2;                        // second stage
   } jtc_sync_regs_t;
   jtc_sync_regs_t r_reg;                  // registered stages
   jtc_sync_regs_t r_next;                 // next stages
   // shift pins one stage per clock
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = pins_in;
      r_next.s2 = r_reg.s1;
   end
   // reset all pin stages to zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) r_reg <= '0;
      else          r_reg <= r_next;
   end
   assign pins_out = r_reg.s2;
endmodule // jtc_sync

// >>> hw/jtc_bsr.sv
`timescale 1ns/1ps
`include "jtc_defines.svh"
module jtc_bsr
   import jtc_pkg::*;
#(
   parameter int LEN = `JTC_BSR_LEN
) (
   input  wire logic           clk_in,
   input  wire logic           reset_in,
   input  wire logic           capture_in,
   input  wire logic           shift_in,
   input  wire logic           update_in,
   input  wire logic           tdi_in,
   input  wire logic [LEN-1:0] pin_in,
   output logic                serial_out,
   output logic [LEN-1:0]      chain_out,
   output logic [LEN-1:0]      par_out
);
   // ***************************************
   // scan chain with latched parallel side
   // ***************************************
   typedef struct packed {
      logic [LEN-1:0] chain;                // shift path
      logic [LEN-1:0] par;                  // latched parallel output
   } jtc_bsr_regs_t;
   jtc_bsr_regs_t r_reg;                   // registered chain
   jtc_bsr_regs_t r_next;                  // next chain
   // strobes are one clock wide and never overlap
   always_comb begin
      r_next = r_reg;
      if (capture_in) r_next.chain = pin_in;
      else if (shift_in) r_next.chain = {tdi_in, r_reg.chain[LEN-1:1]};
      // parallel side moves only on update, so pins stay still
      if (update_in) r_next.par = r_reg.chain;
   end
   // register the chain
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) r_reg <= '0;
      else          r_reg <= r_next;
   end
   assign serial_out = r_reg.chain[0];
   assign chain_out  = r_reg.chain;
   assign par_out    = r_reg.par;
endmodule // jtc_bsr

// >>> dv/jtc_tester.sv
`timescale 1ns/1ps
// ***************************************
// boundary-scan tester on the far side
// ***************************************
module jtc_tester (
   input  wire logic clk_in,
   input  wire logic tdo_in,
   input  wire logic tdo_oe_in,
   output logic      tck_out,
   output logic      tms_out,
   output logic      tdi_out
);
   logic tdo_pin;                           // serial out as seen on the board
   // released pin shows the inverse, so a stray read never matches
   assign tdo_pin = tdo_oe_in ? tdo_in : ~tdo_in;
   // test clock stands low outside frames
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one test clock period: tms, tdi move on the fall, tdo read before the rise
   task automatic bit_io(input logic tms, input logic tdi, output logic tdo, output logic oe);
      tms_out = tms;
      tdi_out = tdi;
      repeat (4) @(posedge clk_in);
      #1;
      tdo = tdo_pin;
      oe = tdo_oe_in;
      tck_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      tck_out = 1'b0;
   endtask
endmodule // jtc_tester

// >>> dv/jtc_tb.sv
`timescale 1ns/1ps
`include "jtc_defines.svh"
module tb;
   localparam int          LEN = 8;            // short chain keeps scans brief
   localparam logic [31:0] IDV = 32'h5a3c_0e01; // value is arbitrary
   logic           clk_in;                     // system clock
   logic           reset_in;                   // async reset
   logic           tck, tms, tdi;              // test port pins
   logic [LEN-1:0] pin_in;                     // device pin levels
   logic           tdo, tdo_oe, test_mode;     // observed outputs
   logic [LEN-1:0] pin_out;                    // boundary parallel output
   int             err_total, checks_done, cycles;
   jtc_tap #(.BSR_LEN(LEN), .ID_CODE(IDV)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
      .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .pin_in(pin_in), .tdo_out(tdo),
      .tdo_oe_out(tdo_oe), .pin_out(pin_out), .test_mode_out(test_mode));
   jtc_tester u_tester (.clk_in(clk_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe),
      .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
   // ***************************************
   // shared helpers
   // ***************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // tms sequence, lsb first, data line unused
   task automatic walk(input logic [7:0] seq, input int n);
      logic t, o;
      for (int i = 0; i < n; i++) u_tester.bit_io(seq[i], 1'b0, t, o);
   endtask
   // n bits lsb first, last one leaves the shift state
   task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic t, o;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         u_tester.bit_io(i == n - 1, din[i], t, o);
         dout[i] = t;
         check("tdo_oe shifting", o, 1'b1);
      end
   endtask
   // instruction load from idle back to idle
   task automatic load_ir(input logic [2:0] op);
      logic [31:0] d;
      walk(8'h03, 4);
      shift(3, op, d);
      check("ir capture", d[2:0], `JTC_IR_CAPTURE);
      walk(8'h01, 2);
   endtask
   task automatic read_id();
      logic [31:0] d;
      shift(32, 32'h0, d);
      check("idcode", d, IDV);
      walk(8'h01, 2);
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset();
      check("tdo_oe reset", tdo_oe, 1'b0);
      check("test_mode reset", test_mode, 1'b0);
      check("pin_out reset", pin_out, 8'h00);
      walk(8'h04, 5); // idle, idle, sel-dr, cap-dr, shift-dr
      read_id();
   endtask
   // exit1, pause, exit2 and back into shift-ir before the last bit
   task automatic t_ir_pause();
      logic t0, t1, t2, o;
      walk(8'h03, 4);
      u_tester.bit_io(1'b0, 1'b0, t0, o);
      u_tester.bit_io(1'b1, 1'b0, t1, o);
      u_tester.bit_io(1'b0, 1'b0, t2, o);
      check("oe exit1-ir", o, 1'b0);
      u_tester.bit_io(1'b0, 1'b0, t2, o);
      check("oe pause-ir", o, 1'b0);
      u_tester.bit_io(1'b1, 1'b0, t2, o);
      u_tester.bit_io(1'b0, 1'b0, t2, o);
      check("oe exit2-ir", o, 1'b0);
      u_tester.bit_io(1'b1, 1'b0, t2, o);
      check("oe shift again", o, 1'b1);
      check("ir capture out", {t2, t1, t0}, `JTC_IR_CAPTURE);
      walk(8'h01, 2);
      check("test_mode extest", test_mode, 1'b1);
      check("pin_out after ir", pin_out, 8'h00);
   endtask
   task automatic t_extest_dr();
      logic [31:0] d;
      pin_in = 8'h96;
      walk(8'h01, 3);
      pin_in = 8'h00; // capture must have happened already
      shift(LEN, 32'h3c, d);
      check("boundary capture", d[LEN-1:0], 8'h96);
      check("pin_out before update", pin_out, 8'h00);
      walk(8'h0c, 4); // pause, pause, exit2, update-dr
      walk(8'h00, 1);
      check("pin_out updated", pin_out, 8'h3c);
   endtask
   task automatic t_bypass();
      logic [31:0] d;
      walk(8'h03, 4);
      shift(3, `JTC_OP_BYPASS, d);
      walk(8'h03, 4); // update-ir straight to sel-dr
      shift(4, 32'hb, d);
      check("bypass path", d[3:0], 4'h6);
      walk(8'h01, 2);
      check("test_mode bypass", test_mode, 1'b0);
   endtask
   // sample/preload: pins captured, device stays in normal mode
   task automatic t_sample();
      logic [31:0] d;
      load_ir(`JTC_OP_SAMPLE);
      check("test_mode sample", test_mode, 1'b0);
      pin_in = 8'h5a;
      walk(8'h01, 3); // sel-dr, cap-dr, shift-dr
      pin_in = 8'h00;
      shift(LEN, 32'ha5, d);
      check("sample capture", d[LEN-1:0], 8'h5a);
      walk(8'h01, 2); // update-dr, idle
      check("pin_out preload", pin_out, 8'ha5);
   endtask
   task automatic t_tms_reset();
      load_ir(`JTC_OP_EXTEST);
      walk(8'h07, 3); // sel-dr, sel-ir, reset
      check("test_mode sel-ir reset", test_mode, 1'b0);
      walk(8'h00, 1);
      load_ir(`JTC_OP_EXTEST);
      walk(8'h01, 3);
      walk(8'hff, 5);
      check("test_mode five highs", test_mode, 1'b0);
      check("tdo_oe five highs", tdo_oe, 1'b0);
      walk(8'hff, 3);
      walk(8'h02, 4);
      read_id();
   endtask
   // ***************************************
   // closing, timeout, clock, main
   // ***************************************
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // limit sized well above the roughly 1430 cycles the scans need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      reset_in = 1'b1;
      pin_in = '0;
      repeat (3) @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      t_reset();
      t_ir_pause();
      t_extest_dr();
      t_bypass();
      t_sample();
      t_tms_reset();
      give_verdict();
   end
endmodule // tb
